// file: psc_store.sv
`timescale 1ns/10ps
`include "psc_map.svh"
// ==========================================================
// parameter store with working copy and applied copy
module psc_store (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link writes
  input wire psc_pkg::psc_write_type linkWr,
  input wire psc_pkg::psc_class_type wrClass,
  // commit events
  input wire logic motionBusy,
  input wire logic configCmd,
  // non-volatile store read port
  output psc_pkg::psc_nvreq_type nvReq,
  input wire logic [31:0] nvData,
  // motion-side read of applied values
  input wire logic [5:0] rdIndex,
  output logic [31:0] rdData,
  // status
  output logic loadDone,
  output logic recalcBusy,
  output logic pendingAny
);
  import psc_pkg::*;

  typedef enum logic [1:0] {LOAD, WAITNV, RECALC, RUN} psc_state_type;

  // ==========================================================
  // storage
  logic [31:0] work_r [0:63];
  logic [31:0] applied_r [0:63];
  logic [1:0] cls_r [0:63];
  logic [63:0] pend_r;
  psc_state_type state_r;
  logic [6:0] ldIdx_r;
  logic [1:0] lat_r;
  logic loadDone_r;
  logic [31:0] rdData_r;
  logic recStart;
  logic recDone;
  logic commitStop;
  logic commitCfg;
  logic immWr;

  assign commitStop = !motionBusy && (state_r == RUN);
  assign commitCfg = configCmd && (state_r == RUN);
  assign immWr = linkWr.valid && (state_r == RUN) && (wrClass == PSC_IMM);

  // ==========================================================
  // power-up load sequence
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= LOAD;
      ldIdx_r <= 7'h00;
      lat_r <= 2'h0;
      loadDone_r <= 1'b0;
    end else begin
      case (state_r)
        LOAD: begin
          if (ldIdx_r == 7'h40) begin
            state_r <= RECALC;
          end else begin
            lat_r <= `PSC_NV_LAT;
            state_r <= WAITNV;
          end
        end
        WAITNV: begin
          if (lat_r == 2'h1) begin
            ldIdx_r <= ldIdx_r + 7'h01;
            state_r <= LOAD;
          end
          lat_r <= lat_r - 2'h1;
        end
        RECALC: begin
          if (recDone) begin
            loadDone_r <= 1'b1;
            state_r <= RUN;
          end
        end
        RUN: state_r <= RUN;
        default: state_r <= LOAD;
      endcase
    end
  end

  // store is only read, never written
  assign nvReq.req = (state_r == LOAD) && (ldIdx_r != 7'h40);
  assign nvReq.addr = ldIdx_r[5:0];

  // ==========================================================
  // working copy: load from store, then link writes only
  always_ff @(posedge clk) begin
    if (state_r == WAITNV && lat_r == 2'h1) begin
      work_r[ldIdx_r[5:0]] <= nvData;
    end else if (linkWr.valid && state_r == RUN) begin
      work_r[linkWr.index] <= linkWr.data;
    end
  end

  // class tags captured with each accepted write; writes during the load leave them alone
  always_ff @(posedge clk) begin
    if (linkWr.valid && state_r == RUN) begin
      cls_r[linkWr.index] <= wrClass;
    end
  end

  // ==========================================================
  // pending flags and applied copy; a new write wins over a commit clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pend_r <= 64'h0;
    end else begin
      for (int i = 0; i < 64; i++) begin
        // power-class writes never pend, so they cannot trigger a recalculation this session
        if (linkWr.valid && state_r == RUN && linkWr.index == 6'(i) &&
            wrClass != PSC_IMM && wrClass != PSC_PWR) begin
          pend_r[i] <= 1'b1;
        end else if (pend_r[i] && cls_r[i] == `PSC_CLS_B && commitStop) begin
          pend_r[i] <= 1'b0;
        end else if (pend_r[i] && cls_r[i] == `PSC_CLS_C && commitCfg) begin
          pend_r[i] <= 1'b0;
        end
      end
    end
  end

  // applied copy follows the working copy on its commit event; the load and immediate-class writes update it at once
  always_ff @(posedge clk) begin
    for (int i = 0; i < 64; i++) begin
      if (state_r == WAITNV && lat_r == 2'h1 && ldIdx_r[5:0] == 6'(i)) begin
        applied_r[i] <= nvData;
      end else if (immWr && linkWr.index == 6'(i)) begin
        applied_r[i] <= linkWr.data;
      end else if (pend_r[i] && cls_r[i] == `PSC_CLS_B && commitStop) begin
        applied_r[i] <= work_r[i];
      end else if (pend_r[i] && cls_r[i] == `PSC_CLS_C && commitCfg) begin
        applied_r[i] <= work_r[i];
      end
    end
  end

  // recalculation starts once load ends, on an immediate-class write, or on a commit in run while any flag is pending; the timer takes it only when idle
  always_comb begin
    recStart = 1'b0;
    if (state_r == RECALC) begin
      recStart = 1'b1;
    end else if (immWr) begin
      recStart = 1'b1;
    end else if (state_r == RUN && (commitCfg || commitStop) && |pend_r) begin
      recStart = 1'b1;
    end
  end

  psc_recalc u_recalc (
    .clk(clk),
    .rst_n(rst_n),
    .start(recStart),
    .busy(recalcBusy),
    .done(recDone)
  );

  // registered read of the applied copy
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdData_r <= 32'h0;
    end else begin
      rdData_r <= applied_r[rdIndex];
    end
  end

  assign rdData = rdData_r;
  assign loadDone = loadDone_r;
  assign pendingAny = |pend_r;
endmodule

// file: psc_map.svh
`ifndef PSC_MAP_SVH
`define PSC_MAP_SVH
// ==========================================================
// parameter store geometry
`define PSC_NPARAM 64
`define PSC_AW 6
`define PSC_DW 32
// class codes kept per parameter (two bits)
`define PSC_CLS_A 2'h0
`define PSC_CLS_B 2'h1
`define PSC_CLS_C 2'h2
`define PSC_CLS_P 2'h3
// non-volatile store read latency in cycles
`define PSC_NV_LAT 2'h2
// recalculation duration in cycles
`define PSC_RECALC_CYC 4'h4
`endif

// file: psc_pkg.sv
package psc_pkg;
  typedef enum logic [1:0] {PSC_IMM, PSC_STOP, PSC_CFG, PSC_PWR} psc_class_type;
  // one parameter write from the link
  typedef struct packed {
    logic valid;
    logic [5:0] index;
    logic [31:0] data;
  } psc_write_type;
  // non-volatile read port
  typedef struct packed {
    logic req;
    logic [5:0] addr;
  } psc_nvreq_type;
endpackage

// file: psc_recalc.sv
`timescale 1ns/10ps
`include "psc_map.svh"
// ==========================================================
// recalculation timer: fixed busy period per start request taken while idle
module psc_recalc (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic start,
  output logic busy,
  output logic done
);
  logic [3:0] cnt_r;
  // count down while busy; a start during busy is ignored and not queued
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r <= 4'h0;
    end else if (start && cnt_r == 4'h0) begin
      cnt_r <= `PSC_RECALC_CYC;
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end
  assign busy = (cnt_r != 4'h0);
  assign done = (cnt_r == 4'h1);
endmodule

// file: psc_store_assertions.sv
`timescale 1ns/10ps
// ====
// port checker for the parameter store
module psc_store_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link writes and commit events
  input wire psc_pkg::psc_write_type linkWr,
  input wire psc_pkg::psc_class_type wrClass,
  input wire logic motionBusy,
  input wire logic configCmd,
  // store port and status
  input wire psc_pkg::psc_nvreq_type nvReq,
  input wire logic loadDone,
  input wire logic recalcBusy,
  input wire logic pendingAny
);
  import psc_pkg::*;
  logic wrOk;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // writes during the load are dropped, so only these count
  assign wrOk = linkWr.valid && loadDone;
  a_recalc_len: assert property ($rose(recalcBusy) |-> recalcBusy[*4])
    else $error("recalc too short");
  a_load_first: assert property (nvReq.req |-> !loadDone && !recalcBusy)
    else $error("recalc during load");
  a_done_holds: assert property (loadDone |=> loadDone)
    else $error("load flag dropped");
  a_imm_apply: assert property (wrOk && wrClass == PSC_IMM |-> ##[1:2] recalcBusy)
    else $error("no recalc on write");
  a_stop_wait: assert property (wrOk && wrClass == PSC_STOP && motionBusy |=> pendingAny)
    else $error("stop write not held");
  a_cfg_wait: assert property (wrOk && wrClass == PSC_CFG |=> pendingAny)
    else $error("config write not held");
  a_pwr_quiet: assert property (wrOk && wrClass == PSC_PWR && !recalcBusy && !pendingAny
    |=> !recalcBusy)
    else $error("power write applied");
  a_pend_hold: assert property (pendingAny && motionBusy && !configCmd |=> pendingAny)
    else $error("pending lost");
  // main traffic seen
  c_stop: cover property (wrOk && wrClass == PSC_STOP);
  c_stop_commit: cover property ($fell(motionBusy) && pendingAny);
  c_cfg_commit: cover property (configCmd && pendingAny);
endmodule
bind psc_store psc_store_assertions u_chk (.clk, .rst_n, .linkWr, .wrClass, .motionBusy,
  .configCmd, .nvReq, .loadDone, .recalcBusy, .pendingAny);

// file: psc_nv_model.sv
`timescale 1ns/10ps
// ====
// read-only store model; nothing writes it, so it outlives every reset
module psc_nv_model (
  // clock
  input wire logic clk,
  // read port
  input wire psc_pkg::psc_nvreq_type nvReq,
  output logic [31:0] nvData
);
  logic [5:0] addr1;
  logic [5:0] addr2;
  logic vld1;
  logic vld2;
  logic tgl = 1'b0;
  // two register stages match the two-cycle read latency; idle data toggles
  always @(posedge clk) begin
    addr1 <= nvReq.addr;
    vld1 <= nvReq.req;
    addr2 <= addr1;
    vld2 <= vld1;
    tgl <= ~tgl;
  end
  assign nvData = vld2 ? {16'h5a5a, 10'h0, addr2} : {32{tgl}};
endmodule

// file: tb_parameter_store_commit.sv
`timescale 1ns/10ps
// ====
// bench for the parameter store
module tb_parameter_store_commit;
  import psc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  psc_write_type linkWr = '0;
  psc_class_type wrClass = PSC_IMM;
  logic motionBusy = 1'b0;
  logic configCmd = 1'b0;
  logic [5:0] rdIndex = 6'h0;
  psc_nvreq_type nvReq;
  logic [31:0] nvData, rdData;
  logic loadDone, recalcBusy, pendingAny;
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;
  // 100 ns period
  always #50 clk = ~clk;
  psc_store DUT (.clk, .rst_n, .linkWr, .wrClass, .motionBusy, .configCmd, .nvReq,
    .nvData, .rdIndex, .rdData, .loadDone, .recalcBusy, .pendingAny);
  psc_nv_model nvm (.clk, .nvReq, .nvData);
  // store word as the model holds it
  function automatic logic [31:0] nv(input logic [5:0] i);
    return {16'h5a5a, 10'h0, i};
  endfunction
  task automatic chk(input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // inputs always move 1 ns after the edge
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [5:0] i, psc_class_type c, logic [31:0] d);
    linkWr = {1'b1, i, d};
    wrClass = c;
    step();
    linkWr.valid = 1'b0;
  endtask
  task automatic rd(input logic [5:0] i, logic [31:0] exp);
    rdIndex = i;
    step();
    chk(rdData, exp);
  endtask
  // a write during the load must be dropped
  task automatic do_reset();
    rst_n = 1'b0;
    repeat (12) step();
    rst_n = 1'b1;
    wr(6'h5, PSC_IMM, 32'hdead0005);
    for (int k = 0; k < 400 && !loadDone; k++) step();
    chk(loadDone, 32'h1);
    rd(6'h5, nv(6'h5));
  endtask
  task automatic t_load();
    for (int i = 0; i < 64; i++) rd(i[5:0], nv(i[5:0]));
  endtask
  task automatic t_commit();
    motionBusy = 1'b1;
    wr(6'h1, PSC_IMM, 32'h11);
    rd(6'h1, 32'h11);
    chk(recalcBusy, 32'h1);
    wr(6'h2, PSC_STOP, 32'h22);
    rd(6'h2, nv(6'h2));
    chk(pendingAny, 32'h1);
    motionBusy = 1'b0;
    repeat (2) step();
    rd(6'h2, 32'h22);
    chk(pendingAny, 32'h0);
    wr(6'h3, PSC_CFG, 32'h33);
    repeat (3) step();
    rd(6'h3, nv(6'h3));
    configCmd = 1'b1;
    step();
    configCmd = 1'b0;
    step();
    rd(6'h3, 32'h33);
    wr(6'h4, PSC_PWR, 32'h44);
    configCmd = 1'b1;
    step();
    configCmd = 1'b0;
    repeat (6) step();
    rd(6'h4, nv(6'h4));
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // hang guard, well above the two loads and the scenarios
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      complete_run();
    end
  end
  initial begin
    do_reset();
    t_load();
    t_commit();
    do_reset();
    rd(6'h1, nv(6'h1));
    rd(6'h4, nv(6'h4));
    complete_run();
  end
endmodule
